// File: verilog/pmt_pkg.sv
package pmt_pkg;

    // Register byte offsets
    localparam logic [11:0] PMT_OFS_CONTROL  = 12'h000;
    localparam logic [11:0] PMT_OFS_COUNT    = 12'h004;
    localparam logic [11:0] PMT_OFS_PERIOD   = 12'h008;
    localparam logic [11:0] PMT_OFS_FLAG     = 12'h00C;
    localparam logic [11:0] PMT_OFS_MASK     = 12'h010;

    // Control field positions
    localparam int PMT_CTL_PRE_LSB  = 0;
    localparam int PMT_CTL_RUN_BIT  = 2;
    localparam int PMT_CTL_POST_LSB = 3;
    localparam logic [7:0] PMT_CTL_WMASK = 8'h7F;

    // Prescale select codes
    localparam logic [1:0] PMT_PRE_DIV1 = 2'h0;
    localparam logic [1:0] PMT_PRE_DIV4 = 2'h1;
    localparam logic [3:0] PMT_PRE_TC1  = 4'h0;
    localparam logic [3:0] PMT_PRE_TC4  = 4'h3;
    localparam logic [3:0] PMT_PRE_TC16 = 4'hF;

    // Reset values
    localparam logic [7:0] PMT_RST_CONTROL = 8'h00;
    localparam logic [7:0] PMT_RST_COUNT   = 8'h00;
    localparam logic [7:0] PMT_RST_PERIOD  = 8'hFF;

    // Instruction clock is pclk divided by four
    localparam logic [1:0] PMT_ICLK_TC = 2'h3;

endpackage

// File: verilog/pmt_div_if.sv
`timescale 1ns/100ps
`default_nettype none
interface pmt_div_if;
    logic       clear;
    logic       step;
    logic [3:0] terminal;
    logic       tick;

    modport owner (output clear, output step, output terminal, input tick);
    modport div   (input clear, input step, input terminal, output tick);
endinterface
`default_nettype wire

// File: verilog/pmt_divider.sv
`timescale 1ns/100ps
`default_nettype none
module pmt_divider
(
    // Clock and reset
    input  wire logic   pclk,
    input  wire logic   presetn,
    // Control
    pmt_div_if.div      ctl
);
    logic [3:0] cnt_reg;
    logic [3:0] cnt_next;
    logic       wrap;

    assign wrap     = ctl.step && (cnt_reg >= ctl.terminal);
    assign cnt_next = ctl.clear ? 4'h0 : (wrap ? 4'h0 : (ctl.step ? cnt_reg + 4'h1 : cnt_reg));
    assign ctl.tick = wrap && !ctl.clear;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            cnt_reg <= 4'h0;
        else
            cnt_reg <= cnt_next;
    end
endmodule
`default_nettype wire

// File: verilog/pmt_timer.sv
// Operation
// - Timer input is the instruction clock, pclk divided by four, into prescaler.
// - Prescaler divides by 1, 4 or 16; each output increments the count.
// - Count and period registers are 8 bits wide.
// - Count compared with period continuously, counting up from 00h.
// - On match the count returns to 00h at the next increment.
// - Each match advances the postscaler by one.
// - Postscale select bits 6:3, code n gives ratio 1:(n+1).
// - Each postscaler output sets the period match flag.
// - Count and period registers readable and writable at any time.
// - Reset loads count with 00h and period with FFh.
// - Timer runs only while run enable bit 2 is one.
// - Writing the count clears prescaler and postscaler.
// - Writing the control register clears prescaler and postscaler.
// - Any reset clears prescaler and postscaler.
// - Control writes leave the count unchanged.
//
// The address map and the APB interface to the registers are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
module pmt_timer
(
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Interrupt
    output logic             irq
);
    logic [7:0] control_reg;
    logic [7:0] count_value_reg;
    logic [7:0] period_value_reg;
    logic       flag_reg;
    logic       mask_reg;
    logic [1:0] iclk_reg;
    logic [31:0] prdata_reg;
    logic        pready_reg;
    logic        pslverr_reg;
    logic        irq_reg;

    logic [7:0]  count_next;
    logic        flag_next;
    logic [31:0] prdata_next;

    // Bus decode
    logic access;
    logic wr_en;
    logic lane0;
    logic hit_ctl;
    logic hit_cnt;
    logic hit_per;
    logic hit_flg;
    logic hit_msk;
    logic mapped;
    logic wr_ctl;
    logic wr_cnt;
    logic wr_per;
    logic wr_flg;
    logic wr_msk;

    assign access  = psel && !penable;
    // Writes land at the edge where the master samples ready, not at setup
    assign wr_en   = psel && penable && pready_reg && pwrite;
    assign lane0   = pstrb[0];
    assign hit_ctl = (paddr == pmt_pkg::PMT_OFS_CONTROL);
    assign hit_cnt = (paddr == pmt_pkg::PMT_OFS_COUNT);
    assign hit_per = (paddr == pmt_pkg::PMT_OFS_PERIOD);
    assign hit_flg = (paddr == pmt_pkg::PMT_OFS_FLAG);
    assign hit_msk = (paddr == pmt_pkg::PMT_OFS_MASK);
    assign mapped  = hit_ctl || hit_cnt || hit_per || hit_flg || hit_msk;
    assign wr_ctl  = wr_en && lane0 && hit_ctl;
    assign wr_cnt  = wr_en && lane0 && hit_cnt;
    assign wr_per  = wr_en && lane0 && hit_per;
    assign wr_flg  = wr_en && lane0 && hit_flg;
    assign wr_msk  = wr_en && lane0 && hit_msk;

    // Control fields
    logic [1:0] prescale_select;
    logic       timer_run_enable;
    logic [3:0] postscale_select;

    assign prescale_select  = control_reg[pmt_pkg::PMT_CTL_PRE_LSB +: 2];
    assign timer_run_enable = control_reg[pmt_pkg::PMT_CTL_RUN_BIT];
    assign postscale_select = control_reg[pmt_pkg::PMT_CTL_POST_LSB +: 4];

    // Instruction clock enable
    logic iclk_tick;
    assign iclk_tick = (iclk_reg == pmt_pkg::PMT_ICLK_TC);

    // Prescaler and postscaler are cleared together on count or control writes
    logic div_clear;
    assign div_clear = wr_cnt || wr_ctl;

    pmt_div_if pre_if ();
    pmt_div_if post_if ();

    logic [3:0] pre_tc;
    assign pre_tc = (prescale_select == pmt_pkg::PMT_PRE_DIV1) ? pmt_pkg::PMT_PRE_TC1 :
                    (prescale_select == pmt_pkg::PMT_PRE_DIV4) ? pmt_pkg::PMT_PRE_TC4 :
                    pmt_pkg::PMT_PRE_TC16;

    assign pre_if.clear    = div_clear;
    assign pre_if.step     = iclk_tick && timer_run_enable;
    assign pre_if.terminal = pre_tc;

    pmt_divider u_prescaler
    (
        .pclk    (pclk),
        .presetn (presetn),
        .ctl     (pre_if.div)
    );

    // Count path
    logic inc;
    logic match;
    assign inc   = pre_if.tick;
    assign match = (count_value_reg == period_value_reg);

    // Match is acted on at the increment that wraps, so the period is PR+1 ticks
    logic wrap_evt;
    assign wrap_evt = inc && match;

    assign post_if.clear    = div_clear;
    assign post_if.step     = wrap_evt;
    assign post_if.terminal = postscale_select;

    pmt_divider u_postscaler
    (
        .pclk    (pclk),
        .presetn (presetn),
        .ctl     (post_if.div)
    );

    // Software write wins over a simultaneous increment
    assign count_next = wr_cnt   ? pwdata[7:0] :
                        wrap_evt ? pmt_pkg::PMT_RST_COUNT :
                        inc      ? count_value_reg + 8'h01 :
                        count_value_reg;

    // Set wins over a write-one clear
    assign flag_next = post_if.tick || (flag_reg && !(wr_flg && pwdata[0]));

    assign prdata_next = !mapped ? 32'h0000_0000 :
                         hit_ctl ? {24'h00_0000, control_reg} :
                         hit_cnt ? {24'h00_0000, count_value_reg} :
                         hit_per ? {24'h00_0000, period_value_reg} :
                         hit_flg ? {31'h0000_0000, flag_reg} :
                         {31'h0000_0000, mask_reg};

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            iclk_reg <= 2'h0;
        else
            iclk_reg <= iclk_reg + 2'h1;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            control_reg      <= pmt_pkg::PMT_RST_CONTROL;
            count_value_reg  <= pmt_pkg::PMT_RST_COUNT;
            period_value_reg <= pmt_pkg::PMT_RST_PERIOD;
        end
        else
        begin
            if (wr_ctl)
                control_reg <= pwdata[7:0] & pmt_pkg::PMT_CTL_WMASK;
            count_value_reg <= count_next;
            if (wr_per)
                period_value_reg <= pwdata[7:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            flag_reg <= 1'b0;
            mask_reg <= 1'b0;
            irq_reg  <= 1'b0;
        end
        else
        begin
            flag_reg <= flag_next;
            if (wr_msk)
                mask_reg <= pwdata[0];
            irq_reg <= flag_next && (wr_msk ? pwdata[0] : mask_reg);
        end
    end

    // Answer in the first access cycle: request sampled at setup, ready in access
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata_reg  <= 32'h0000_0000;
            pready_reg  <= 1'b0;
            pslverr_reg <= 1'b0;
        end
        else
        begin
            pready_reg  <= access;
            pslverr_reg <= access && !mapped;
            // Refused accesses answer zero data, writes included
            if (access && (!pwrite || !mapped))
                prdata_reg <= prdata_next;
        end
    end

    assign prdata  = prdata_reg;
    assign pready  = pready_reg;
    assign pslverr = pslverr_reg;
    assign irq     = irq_reg;
endmodule
`default_nettype wire

// File: sim/pmt_timer_assertions.sv
`timescale 1ns/100ps
`default_nettype none
module pmt_timer_assertions
(
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave side
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr
);
    default clocking @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence setup_s;
        psel && !penable;
    endsequence

    sequence rd_s(a);
        pready && !pwrite && paddr == a;
    endsequence

    ready_after_setup_a: assert property (setup_s |=> pready) else $error("no ready after setup");
    ready_pulse_a: assert property (pready |=> !pready) else $error("ready longer than one cycle");
    ready_cause_a: assert property (pready |-> $past(psel && !penable)) else $error("ready without setup");
    err_data_a: assert property (pslverr |-> pready && prdata == 32'h0) else $error("bad error answer");
    ctl_top_a: assert property (rd_s(pmt_pkg::PMT_OFS_CONTROL) |-> prdata[31:7] == 25'h0)
        else $error("control top bits set");
    count_width_a: assert property (rd_s(pmt_pkg::PMT_OFS_COUNT) |-> prdata[31:8] == 24'h0 && !pslverr)
        else $error("count wider than a byte");
    period_width_a: assert property (rd_s(pmt_pkg::PMT_OFS_PERIOD) |-> prdata[31:8] == 24'h0)
        else $error("period wider than a byte");
    period_ok_a: assert property (rd_s(pmt_pkg::PMT_OFS_PERIOD) |-> !pslverr) else $error("period refused");
endmodule
`default_nettype wire

// File: sim/test_period_match_timer8.sv
`timescale 1ns/100ps
`default_nettype none
module test_period_match_timer8;
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        irq;
    logic [31:0] rd;
    logic        err;
    logic [7:0]  pr;
    logic [3:0]  po;
    int          num_errors = 0;
    int          checks_done = 0;
    int          seed = 71;
    int          cyc = 0;
    int          t0;
    int          t1;

    pmt_timer DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
                   .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata), .pready(pready),
                   .pslverr(pslverr), .irq(irq));

    initial
    begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    always @(posedge pclk) cyc <= cyc + 1;

    task automatic finish_test();
        if (num_errors == 0 && checks_done > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic check(string nm, logic [31:0] seen, logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    function automatic int exp_len(logic [7:0] p, logic [1:0] s, logic [3:0] q);
        return (p + 1) * (s == 2'h0 ? 1 : s == 2'h1 ? 4 : 16) * (q + 1) * 4;
    endfunction

    task automatic apb(logic wr, logic [11:0] a, logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20)
        begin
            num_errors++;
            finish_test();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rchk(string nm, logic [11:0] a, logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        check(nm, rd, exp);
    endtask

    // Cycle stamp of the first edge that sees irq high
    task automatic wait_irq(output int t);
        int n;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end while (irq !== 1'b1 && n < 5000);
        if (n >= 5000)
        begin
            num_errors++;
            finish_test();
        end
        t = cyc;
    endtask

    task automatic reset_and_check();
        presetn <= 1'b0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        rchk("ctl", pmt_pkg::PMT_OFS_CONTROL, 32'h0);
        rchk("count", pmt_pkg::PMT_OFS_COUNT, 32'h0);
        rchk("period", pmt_pkg::PMT_OFS_PERIOD, 32'hFF);
        rchk("flag", pmt_pkg::PMT_OFS_FLAG, 32'h0);
    endtask

    initial
    begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h0;
        pwdata = 32'h0;
        reset_and_check();
        apb(1'b1, pmt_pkg::PMT_OFS_CONTROL, 32'hFFFF_FFFB);
        rchk("ctl", pmt_pkg::PMT_OFS_CONTROL, 32'h7B);
        pr = 8'($random(seed));
        apb(1'b1, pmt_pkg::PMT_OFS_PERIOD, {24'h0, pr});
        rchk("period", pmt_pkg::PMT_OFS_PERIOD, {24'h0, pr});
        apb(1'b1, pmt_pkg::PMT_OFS_COUNT, {24'h0, ~pr});
        repeat (40) @(posedge pclk);
        rchk("count", pmt_pkg::PMT_OFS_COUNT, {24'h0, ~pr});
        apb(1'b1, pmt_pkg::PMT_OFS_CONTROL, 32'h3);
        rchk("count", pmt_pkg::PMT_OFS_COUNT, {24'h0, ~pr});
        apb(1'b0, 12'h014, 32'h0);
        check("err", {31'h0, err}, 32'h1);
        apb(1'b1, pmt_pkg::PMT_OFS_MASK, 32'h1);
        for (int k = 0; k < 4; k++)
        begin
            pr = 8'({$random(seed)} % 6);
            po = 4'(1 + {$random(seed)} % 3);
            // Stop first so the count never runs while above a smaller period
            apb(1'b1, pmt_pkg::PMT_OFS_CONTROL, 32'h0);
            apb(1'b1, pmt_pkg::PMT_OFS_PERIOD, {24'h0, pr});
            apb(1'b1, pmt_pkg::PMT_OFS_COUNT, 32'h0);
            apb(1'b1, pmt_pkg::PMT_OFS_CONTROL, {25'h0, po, 1'b1, 2'(k)});
            apb(1'b1, pmt_pkg::PMT_OFS_FLAG, 32'h1);
            wait_irq(t0);
            apb(1'b1, pmt_pkg::PMT_OFS_FLAG, 32'h1);
            wait_irq(t1);
            check("len", t1 - t0, exp_len(pr, 2'(k), po));
        end
        apb(1'b1, pmt_pkg::PMT_OFS_MASK, 32'h0);
        apb(1'b1, pmt_pkg::PMT_OFS_FLAG, 32'h1);
        repeat (1600) @(posedge pclk);
        check("irq", {31'h0, irq}, 32'h0);
        rchk("flag", pmt_pkg::PMT_OFS_FLAG, 32'h1);
        reset_and_check();
        finish_test();
    end
endmodule

bind pmt_timer pmt_timer_assertions u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
                                           .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
                                           .pready(pready), .pslverr(pslverr));
`default_nettype wire
